// ==== verilog/lfs_pkg.sv ====
// lfs_pkg: constants, register map and carrier types of the frame parameter sequencer.
// assumes a 100 MHz clock and an AHB-Lite master with single word transfers.
//
// Function
// - interpolate each parameter toward new bank value
// - frame interrupt toggles the bank context bit
// - after exchange hold present values until resumed
// - interpolation enable instruction turns interpolation on
// - no timer reload means no further interrupts
// - voicing load takes accumulator bit zero
// - zero new bank ramps parameters down to zero
package lfs_pkg;

  // register byte offsets on the slave port
  localparam logic [7:0] LFS_OFF_CMD      = 8'h00;  // instruction strobes, write only
  localparam logic [7:0] LFS_OFF_ACC      = 8'h04;  // accumulator operand
  localparam logic [7:0] LFS_OFF_PRESCALE = 8'h08;  // frame prescale
  localparam logic [7:0] LFS_OFF_STATUS   = 8'h0C;  // sequencer state, read only
  localparam logic [7:0] LFS_OFF_IRQ_STAT = 8'h10;  // sticky events, write one to clear
  localparam logic [7:0] LFS_OFF_IRQ_MASK = 8'h14;  // event enables, same layout
  localparam logic [1:0] LFS_SEL_NEW      = 2'h1;   // 0x40.. new-value bank slots
  localparam logic [1:0] LFS_SEL_PRES     = 2'h2;   // 0x80.. present-value bank slots
  localparam logic [1:0] LFS_SEL_CUR      = 2'h3;   // 0xC0.. interpolated values, read only

  // instruction strobe bit positions in the command register
  localparam int LFS_CMD_START    = 0;
  localparam int LFS_CMD_STOP     = 1;
  localparam int LFS_CMD_INTERP   = 2;  // interp_on_instr
  localparam int LFS_CMD_IRQ_ON   = 3;
  localparam int LFS_CMD_IRQ_OFF  = 4;  // irq_off_instr
  localparam int LFS_CMD_VOICING  = 5;  // voicing_load_instr
  localparam int LFS_CMD_TIMER    = 6;  // timer_load_instr

  // event bit positions in status and mask registers
  localparam int LFS_EV_FRAME     = 0;
  localparam int LFS_EV_PITCH_BAD = 1;
  localparam int LFS_EV_W         = 2;

  // values after reset
  localparam logic [9:0]          LFS_ACC_RST      = 10'h000;
  localparam logic [9:0]          LFS_PRESCALE_RST = 10'h031;  // 200 samples a frame
  localparam logic [LFS_EV_W-1:0] LFS_MASK_RST     = 2'h0;

  // timing: sample rate gives the sample tick
  localparam int LFS_CLK_HZ        = 100_000_000;
  localparam int LFS_SAMPLE_HZ     = 8_000;
  localparam int LFS_SAMPLE_CYCLES = LFS_CLK_HZ / LFS_SAMPLE_HZ;
  localparam int LFS_SAMPLES_PER_Q = 4;   // prescaler counts groups of four samples
  localparam int LFS_STEP_SHIFT    = 3;   // interpolation step is an eighth of the gap
  localparam logic [9:0] LFS_PITCH_SAFE = 10'h00C;  // lowest pitch that starts without a pitch flag

  // sequencer states, gray along idle -> hold -> interp
  typedef enum logic [1:0] {
    LFS_ST_IDLE   = 2'b00,
    LFS_ST_HOLD   = 2'b01,
    LFS_ST_INTERP = 2'b11
  } lfs_state_t;

  // captured AHB address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } lfs_ahb_req_t;

  // decoded instruction strobes, one cycle each
  typedef struct packed {
    logic timer_load;
    logic voicing_load;
    logic irq_off;
    logic irq_on;
    logic interp_on;
    logic stop;
    logic start;
  } lfs_cmd_t;

endpackage

// ==== verilog/lfs_frame_seq.sv ====
// lfs_frame_seq: frame-level parameter sequencer with two parameter banks,
// interpolation, frame timer, voicing and an AHB-Lite register slave.
// assumes one clock, single word AHB transfers, and a program that loads frames.
`timescale 1ns/1ns

module lfs_frame_seq #(
  parameter int N_PARAM       = 12,                          // pitch, energy, k1..k10
  parameter int PW            = 10,                          // parameter width
  parameter int SAMPLE_CYCLES = lfs_pkg::LFS_SAMPLE_CYCLES   // clocks per sample
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [31:0]                hrdata,
  output logic                       hresp,
  // synthesis side
  output logic [N_PARAM*PW-1:0]      param_out,
  output logic                       voiced,
  output logic                       synth_run,
  output logic                       frame_pulse,
  // interrupt
  output logic                       irq
);
  import lfs_pkg::*;

  localparam int IW = $clog2(N_PARAM);

  // true when an address falls on the given register word
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  // move one step toward the target, never overshooting
  function automatic logic [PW-1:0] step_toward(input logic [PW-1:0] c,
                                                input logic [PW-1:0] t);
    logic [PW-1:0] d;
    logic [PW-1:0] s;
    d = (c < t) ? (t - c) : (c - t);
    s = d >> LFS_STEP_SHIFT;
    if (s == '0) s = {{(PW-1){1'b0}}, 1'b1};
    if (c == t) step_toward = c;
    else if (c < t) step_toward = c + s;
    else step_toward = c - s;
  endfunction

  // bus state
  lfs_ahb_req_t req_reg;                    // address phase held for the data phase
  logic         hreadyout_reg;              // always ready, zero wait states
  logic [31:0]  hrdata_reg;                 // read data for the data phase
  logic [31:0]  rd_next;                    // read mux output

  // software registers
  logic [PW-1:0]         acc_reg;           // accumulator operand
  logic [9:0]            prescale_reg;      // frame prescale
  logic [LFS_EV_W-1:0]   stat_reg;          // sticky events
  logic [LFS_EV_W-1:0]   mask_reg;          // event enables
  logic                  irq_en_reg;        // processor interrupt enable
  logic                  irq_reg;

  // sequencer state
  lfs_state_t            state_reg;
  logic                  ctx_reg;           // selects which bank is present
  logic                  voiced_reg;
  logic                  frame_reg;         // one-cycle frame pulse
  logic [PW-1:0]         bank [2][N_PARAM]; // two parameter banks
  logic [PW-1:0]         cur  [N_PARAM];    // interpolated values

  // timebase and frame timer
  logic [$clog2(SAMPLE_CYCLES+1)-1:0] samp_cnt_reg;
  logic [1:0]            quad_cnt_reg;
  logic [9:0]            pre_cnt_reg;
  logic [7:0]            timer_reg;
  logic                  armed_reg;         // timer loaded and not yet expired

  // ---------------------------------------------------------------- decode
  wire          addr_take = hsel & hready & htrans[1];
  wire          wr_en     = req_reg.valid & req_reg.write;
  wire [7:0]    wa        = req_reg.addr;
  wire [7:0]    ra        = haddr[7:0];
  wire          wr_cmd    = wr_en & hit(wa, LFS_OFF_CMD);
  wire          wr_acc    = wr_en & hit(wa, LFS_OFF_ACC);
  wire          wr_pre    = wr_en & hit(wa, LFS_OFF_PRESCALE);
  wire          wr_stat   = wr_en & hit(wa, LFS_OFF_IRQ_STAT);
  wire          wr_mask   = wr_en & hit(wa, LFS_OFF_IRQ_MASK);
  wire [3:0]    w_idx     = wa[5:2];
  wire          w_idx_ok  = ({28'h0, w_idx} < N_PARAM);
  wire          wr_new    = wr_en & (wa[7:6] == LFS_SEL_NEW) & w_idx_ok;
  wire          wr_pres   = wr_en & (wa[7:6] == LFS_SEL_PRES) & w_idx_ok;
  wire [IW-1:0] w_slot    = w_idx[IW-1:0];
  wire [3:0]    r_idx     = ra[5:2];
  wire          r_idx_ok  = ({28'h0, r_idx} < N_PARAM);
  wire [IW-1:0] r_slot    = r_idx[IW-1:0];

  // instruction strobes from a command write
  lfs_cmd_t cmd;
  assign cmd.start        = wr_cmd & hwdata[LFS_CMD_START];
  assign cmd.stop         = wr_cmd & hwdata[LFS_CMD_STOP];
  assign cmd.interp_on    = wr_cmd & hwdata[LFS_CMD_INTERP];
  assign cmd.irq_on       = wr_cmd & hwdata[LFS_CMD_IRQ_ON];
  assign cmd.irq_off      = wr_cmd & hwdata[LFS_CMD_IRQ_OFF];
  assign cmd.voicing_load = wr_cmd & hwdata[LFS_CMD_VOICING];
  assign cmd.timer_load   = wr_cmd & hwdata[LFS_CMD_TIMER];

  // timebase: counters only run while synthesizing
  wire running     = (state_reg != LFS_ST_IDLE);
  wire samp_tick   = running & (samp_cnt_reg == ($bits(samp_cnt_reg))'(SAMPLE_CYCLES - 1));
  wire quad_tick   = samp_tick & (quad_cnt_reg == 2'(LFS_SAMPLES_PER_Q - 1));
  wire timer_tick  = quad_tick & (pre_cnt_reg == prescale_reg);
  // expiry only when loaded; an unreloaded timer stays silent
  wire expire      = timer_tick & armed_reg & (timer_reg == 8'h00);
  wire pitch_bad   = cmd.start & (acc_reg < LFS_PITCH_SAFE);

  // event sources for the sticky status
  wire [LFS_EV_W-1:0] ev_set;
  assign ev_set[LFS_EV_FRAME]     = expire;
  assign ev_set[LFS_EV_PITCH_BAD] = pitch_bad;

  // ---------------------------------------------------------------- ahb slave
  // address phase captured when the bus is ready; reads answered at the same edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      req_reg       <= '0;
      hreadyout_reg <= 1'b1;
      hrdata_reg    <= 32'h0000_0000;
    end else begin
      req_reg       <= '{valid: addr_take, write: hwrite, addr: ra};
      hreadyout_reg <= 1'b1;
      hrdata_reg    <= (addr_take & ~hwrite) ? rd_next : 32'h0000_0000;
    end
  end

  // read mux; unmapped words and write-only registers read as zero
  always_comb begin
    rd_next = 32'h0000_0000;
    if (hit(ra, LFS_OFF_ACC)) begin
      rd_next[PW-1:0] = acc_reg;
    end else if (hit(ra, LFS_OFF_PRESCALE)) begin
      rd_next[9:0] = prescale_reg;
    end else if (hit(ra, LFS_OFF_STATUS)) begin
      rd_next[15:0] = {timer_reg, armed_reg, irq_en_reg, voiced_reg, ctx_reg,
                       2'b00, state_reg};
    end else if (hit(ra, LFS_OFF_IRQ_STAT)) begin
      rd_next[LFS_EV_W-1:0] = stat_reg;
    end else if (hit(ra, LFS_OFF_IRQ_MASK)) begin
      rd_next[LFS_EV_W-1:0] = mask_reg;
    end else if ((ra[7:6] == LFS_SEL_NEW) && r_idx_ok) begin
      rd_next[PW-1:0] = bank[~ctx_reg][r_slot];
    end else if ((ra[7:6] == LFS_SEL_PRES) && r_idx_ok) begin
      rd_next[PW-1:0] = bank[ctx_reg][r_slot];
    end else if ((ra[7:6] == LFS_SEL_CUR) && r_idx_ok) begin
      rd_next[PW-1:0] = cur[r_slot];
    end
  end

  // ---------------------------------------------------------------- registers
  // plain software registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_reg      <= LFS_ACC_RST;
      prescale_reg <= LFS_PRESCALE_RST;
      mask_reg     <= LFS_MASK_RST;
    end else begin
      if (wr_acc) acc_reg <= hwdata[PW-1:0];
      if (wr_pre) prescale_reg <= hwdata[9:0];
      if (wr_mask) mask_reg <= hwdata[LFS_EV_W-1:0];
    end
  end

  // sticky events: a set in the clearing cycle wins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= (stat_reg & ~(wr_stat ? hwdata[LFS_EV_W-1:0] : '0)) | ev_set;
    end
  end

  // interrupt enable and level output; a masked event still stays sticky
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_en_reg <= 1'b0;
      irq_reg    <= 1'b0;
    end else begin
      if (cmd.irq_off) irq_en_reg <= 1'b0;
      else if (cmd.irq_on) irq_en_reg <= 1'b1;
      irq_reg <= irq_en_reg & |(stat_reg & mask_reg);
    end
  end

  // ---------------------------------------------------------------- timebase
  // sample counter, group-of-four counter and frame prescaler
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      samp_cnt_reg <= '0;
      quad_cnt_reg <= 2'h0;
      pre_cnt_reg  <= 10'h000;
    end else if (!running) begin
      samp_cnt_reg <= '0;
      quad_cnt_reg <= 2'h0;
      pre_cnt_reg  <= 10'h000;
    end else begin
      samp_cnt_reg <= samp_tick ? '0 : samp_cnt_reg + 1'b1;
      if (samp_tick) quad_cnt_reg <= quad_cnt_reg + 2'h1;
      if (timer_tick) pre_cnt_reg <= 10'h000;
      else if (quad_tick) pre_cnt_reg <= pre_cnt_reg + 10'h001;
    end
  end

  // frame timer: loaded from the accumulator, counts down, disarms at expiry
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timer_reg <= 8'h00;
      armed_reg <= 1'b0;
    end else if (cmd.stop) begin
      armed_reg <= 1'b0;
    end else if (cmd.timer_load) begin
      timer_reg <= acc_reg[7:0];
      armed_reg <= 1'b1;
    end else if (expire) begin
      armed_reg <= 1'b0;
    end else if (timer_tick && armed_reg) begin
      timer_reg <= timer_reg - 8'h01;
    end
  end

  // ---------------------------------------------------------------- sequencer
  // state, context and voicing; stop resets the context bit, start keeps it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg  <= LFS_ST_IDLE;
      ctx_reg    <= 1'b0;
      voiced_reg <= 1'b0;
      frame_reg  <= 1'b0;
    end else begin
      frame_reg <= expire;
      if (cmd.voicing_load) voiced_reg <= acc_reg[0];
      case (state_reg)
        LFS_ST_IDLE: begin
          if (cmd.start) state_reg <= LFS_ST_HOLD;
          if (cmd.stop) ctx_reg <= 1'b0;
        end
        LFS_ST_HOLD, LFS_ST_INTERP: begin
          if (cmd.stop) begin
            state_reg <= LFS_ST_IDLE;
            ctx_reg   <= 1'b0;
          end else if (expire) begin
            ctx_reg   <= ~ctx_reg;
            state_reg <= LFS_ST_HOLD;
          end else if (cmd.interp_on) begin
            state_reg <= LFS_ST_INTERP;
          end
        end
        default: state_reg <= LFS_ST_IDLE;
      endcase
    end
  end

  // parameter banks: new and present slots both follow the context;
  // start places the accumulator pitch in the present bank
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int b = 0; b < 2; b++) begin
        for (int i = 0; i < N_PARAM; i++) begin
          bank[b][i] <= '0;
        end
      end
    end else begin
      if (wr_new) bank[~ctx_reg][w_slot] <= hwdata[PW-1:0];
      if (wr_pres) bank[ctx_reg][w_slot] <= hwdata[PW-1:0];
      if (cmd.start && !running) bank[ctx_reg][0] <= acc_reg;
    end
  end

  // interpolated value per parameter
  genvar g;
  generate
    for (g = 0; g < N_PARAM; g++) begin : g_par
      wire [PW-1:0] tgt  = bank[~ctx_reg][g];   // new-value entry
      wire [PW-1:0] pres = bank[ctx_reg][g];    // present-value entry
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          cur[g] <= '0;
        end else if (!running) begin
          // track the present bank so start begins from the first frame
          cur[g] <= (cmd.start && g == 0) ? acc_reg : pres;
        end else if (expire) begin
          cur[g] <= tgt;
        end else if (state_reg == LFS_ST_INTERP && samp_tick) begin
          cur[g] <= step_toward(cur[g], tgt);
        end
      end
      assign param_out[g*PW +: PW] = cur[g];
    end
  endgenerate

  // ---------------------------------------------------------------- outputs
  assign hreadyout   = hreadyout_reg;
  assign hrdata      = hrdata_reg;
  assign hresp       = 1'b0;
  assign voiced      = voiced_reg;
  assign synth_run   = (state_reg != LFS_ST_IDLE);
  assign frame_pulse = frame_reg;
  assign irq         = irq_reg;

  // hsize is unused: only whole words are decoded
  wire unused_ok = &{1'b0, hsize, haddr[31:8], hwdata[31:PW]};

endmodule // lfs_frame_seq

// ==== bench/lfs_frame_seq_properties.sv ====
// lfs_seq_props: port-level checks of the frame sequencer, bound into it.
// assumes a zero-wait slave whose command strobes act at the end of the data phase.
`timescale 1ns/1ns

module lfs_seq_props #(
  parameter int N_PARAM = 12,  // parameter slots
  parameter int PW      = 10   // slot width
) (
  // clock and reset
  input wire logic                    clk,
  input wire logic                    resetn,
  // bus
  input wire logic                    hsel,
  input wire logic [31:0]             haddr,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic [31:0]             hwdata,
  input wire logic                    hready,
  input wire logic                    hreadyout,
  input wire logic [31:0]             hrdata,
  input wire logic                    hresp,
  // synthesis side and interrupt
  input wire logic [N_PARAM*PW-1:0]   param_out,
  input wire logic                    voiced,
  input wire logic                    synth_run,
  input wire logic                    frame_pulse,
  input wire logic                    irq
);
  import lfs_pkg::*;

  wire        take      = hsel && hready && htrans[1];          // address phase accepted
  wire        rd_take   = take && !hwrite;                      // read accepted
  logic       cmd_ph;                                           // command write data phase
  logic       acc_ph;                                           // accumulator write data phase
  logic [9:0] acc_q;                                            // accumulator shadow
  logic       wr_ph;                                            // any write data phase
  wire        start_cmd = cmd_ph && hwdata[LFS_CMD_START];      // start strobe
  wire        voice_cmd = cmd_ph && hwdata[LFS_CMD_VOICING];    // voicing strobe

  // follow write data phases; the shadow lands on the register's own edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_ph <= 1'b0;
      acc_ph <= 1'b0;
      acc_q  <= LFS_ACC_RST;
      wr_ph  <= 1'b0;
    end else begin
      wr_ph  <= take && hwrite;
      cmd_ph <= take && hwrite && haddr[7:0] == LFS_OFF_CMD;
      acc_ph <= take && hwrite && haddr[7:0] == LFS_OFF_ACC;
      if (acc_ph) begin
        acc_q <= hwdata[9:0];
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // zero wait, OKAY only
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("slave stalled or answered with an error");
  // read data stands only in a read data phase
  rdata_idle_a: assert property (!$past(rd_take) |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  start_run_a: assert property (start_cmd && !hwdata[LFS_CMD_STOP] |=> synth_run)
    else $error("start did not set the sequencer running");
  stop_idle_a: assert property (cmd_ph && hwdata[LFS_CMD_STOP] |=> !synth_run)
    else $error("stop did not idle the sequencer");
  voice_load_a: assert property (voice_cmd |=> voiced == acc_q[0])
    else $error("voicing not taken from accumulator bit zero");
  voice_hold_a: assert property ($changed(voiced) |-> $past(voice_cmd))
    else $error("voicing changed without a voicing load");
  pulse_once_a: assert property (frame_pulse |=> !frame_pulse)
    else $error("frame pulse longer than one cycle");
  pulse_run_a: assert property (frame_pulse |-> $past(synth_run))
    else $error("frame pulse while idle");
  frame_hold_a: assert property (frame_pulse |=> $stable(param_out) [*2])
    else $error("parameters moved right after the exchange");
  // idle outputs follow the present bank one cycle late, so writes and stop are excluded
  idle_still_a: assert property (!synth_run && !$past(synth_run) && !$past(wr_ph)
    && !start_cmd |=> $stable(param_out))
    else $error("parameters moved while idle");
  irq_off_a: assert property (cmd_ph && hwdata[LFS_CMD_IRQ_OFF] && !hwdata[LFS_CMD_IRQ_ON]
    |-> ##2 !irq)
    else $error("interrupt line high after interrupts were disabled");

  frame_seen_c: cover property (frame_pulse);
  interp_go_c: cover property (cmd_ph && hwdata[LFS_CMD_INTERP] ##1 synth_run);
  irq_drop_c: cover property ($fell(irq));
endmodule // lfs_seq_props

bind lfs_frame_seq lfs_seq_props #(.N_PARAM(N_PARAM), .PW(PW)) u_props (
  .clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
  .hrdata, .hresp, .param_out, .voiced, .synth_run, .frame_pulse, .irq
);

// ==== bench/lfs_prog_model.sv ====
// lfs_prog_model: the synthesis program as an ahb-lite master.
// assumes hready is the slave's hreadyout; the bench calls its tasks one at a time.
`timescale 1ns/1ns

module lfs_prog_model (
  // clock
  input  wire logic        clk,
  // ahb-lite master
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // read results and bus timeout for the bench
  output logic             rd_done,
  output logic [31:0]      rd_data,
  output logic             bus_tmo
);
  import lfs_pkg::*;

  initial begin
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hsize   = 3'h2;   // whole words only
    hwdata  = 32'h0;
    rd_done = 1'b0;
    rd_data = 32'h0;
    bus_tmo = 1'b0;
  end

  // result strobe lasts one cycle
  always @(posedge clk) begin
    if (rd_done) begin
      rd_done <= 1'b0;
    end
  end

  // bounded wait for hready sampled high at a rising edge
  task automatic wait_ready;
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      bus_tmo <= 1'b1;
    end
  endtask

  // one single word transfer; released data shows the inverse, never a held value
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    hwdata  <= ~d;
    rd_data <= hrdata;
    rd_done <= !wr;
  endtask

  // frame length from samples per frame
  task automatic set_frame(input int samples);
    xfer(1'b1, LFS_OFF_PRESCALE, 32'(samples / 4 - 1));
  endtask

  // frame timer reload with the fixed speech value
  task automatic reload;
    xfer(1'b1, LFS_OFF_ACC, 32'h1F);
    xfer(1'b1, LFS_OFF_CMD, 32'h1 << LFS_CMD_TIMER);
  endtask

  // pitch into the accumulator, start, timer, then interrupts
  task automatic start_up(input logic [9:0] pitch);
    xfer(1'b1, LFS_OFF_ACC, {22'h0, pitch});
    xfer(1'b1, LFS_OFF_CMD, 32'h1 << LFS_CMD_START);
    reload();
    xfer(1'b1, LFS_OFF_CMD, 32'h1 << LFS_CMD_IRQ_ON);
  endtask

  // interrupts off first, then stop
  task automatic finish;
    xfer(1'b1, LFS_OFF_CMD, 32'h1 << LFS_CMD_IRQ_OFF);
    xfer(1'b1, LFS_OFF_CMD, 32'h1 << LFS_CMD_STOP);
  endtask
endmodule // lfs_prog_model

// ==== bench/test_lfs_frame_seq.sv ====
// test_lfs_frame_seq: self-checking bench of the frame parameter sequencer.
// assumes the program model as bus master and a sample every four clocks.
`timescale 1ns/1ns

module test_lfs_frame_seq;
  import lfs_pkg::*;

  typedef struct packed {
    logic [31:0] v;  // expected value
    logic [31:0] m;  // bits that matter
  } lfs_note_t;

  localparam logic [31:0] PM = 32'h3FF;  // one parameter slot

  logic         clk;
  logic         resetn;
  logic         prb;          // asks the monitor to sample irq
  wire          hsel, hwrite, hreadyout, hresp, voiced, synth_run, frame_pulse, irq;
  wire [31:0]   haddr, hwdata, hrdata, rd_data;
  wire [1:0]    htrans;
  wire [2:0]    hsize;
  wire [119:0]  param_out;
  wire          rd_done, bus_tmo;
  lfs_note_t    notes[$];     // oldest expectation first
  lfs_note_t    n;
  logic [31:0]  got;
  logic [31:0]  acc;
  logic [9:0]   pv[12];       // present bank image
  logic [9:0]   nv[12];       // new bank image
  int           errors = 0;
  int           checked = 0;

  lfs_frame_seq #(.SAMPLE_CYCLES(4)) DUT (
    .clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .param_out, .voiced,
    .synth_run, .frame_pulse, .irq
  );
  lfs_prog_model prog (
    .clk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .rd_done, .rd_data, .bus_tmo
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [7:0] slot(input logic [1:0] s, input int i);
    return {s, 4'(i), 2'b00};
  endfunction

  task automatic test_done;
    if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // note the expectation, then read
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back('{e, m});
    prog.xfer(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    prog.xfer(1'b1, a, d);
  endtask

  // irq is sampled at the edge after the request
  task automatic probe(input logic e);
    notes.push_back('{{31'h0, e}, 32'h1});
    @(posedge clk);
    prb <= 1'b1;
    @(posedge clk);
    prb <= 1'b0;
  endtask

  task automatic wait_irq;
    int k = 0;
    while (irq !== 1'b1 && k < 1000) begin
      @(posedge clk);
      k++;
    end
    if (irq !== 1'b1) begin
      errors++;
      test_done();
    end
  endtask

  // results are compared with the oldest note as they appear
  always @(posedge clk) begin
    if (rd_done === 1'b1 || prb === 1'b1) begin
      got = prb ? {31'h0, irq} : rd_data;
      checked++;
      n = notes.pop_front();
      if (((got ^ n.v) & n.m) !== 32'h0) begin
        errors++;
        $display("[ERR] %0t got %h expected %h", $time, got, n.v);
      end
    end
    if (bus_tmo === 1'b1) begin
      errors++;
      test_done();
    end
  end

  initial begin
    resetn = 1'b0;
    prb    = 1'b0;
    void'($urandom(61838));
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    // values after reset, then an unmapped word
    rd(LFS_OFF_STATUS, 32'h0, 32'hFFFF);
    rd(LFS_OFF_PRESCALE, {22'h0, LFS_PRESCALE_RST}, PM);
    rd(LFS_OFF_IRQ_MASK, 32'h0, 32'h3);
    rd(8'h20, 32'h0, 32'hFFFFFFFF);
    prog.set_frame(4);
    for (int i = 0; i < 12; i++) begin
      pv[i] = (i == 0) ? 10'($urandom_range(1023, 12)) : 10'($urandom);
      nv[i] = (i == 0) ? 10'($urandom_range(1023, 12)) : 10'($urandom);
      wr(slot(LFS_SEL_PRES, i), {22'h0, pv[i]});
      wr(slot(LFS_SEL_NEW, i), {22'h0, nv[i]});
    end
    wr(LFS_OFF_IRQ_MASK, 32'h1);
    prog.start_up(pv[0]);
    rd(LFS_OFF_STATUS, 32'hC1, 32'hD3);
    rd(slot(LFS_SEL_CUR, 1), {22'h0, pv[1]}, PM);
    wr(LFS_OFF_CMD, 32'h1 << LFS_CMD_INTERP);
    rd(LFS_OFF_STATUS, 32'h3, 32'h3);
    repeat (350) @(posedge clk);
    for (int i = 0; i < 12; i++) rd(slot(LFS_SEL_CUR, i), {22'h0, nv[i]}, PM);
    wait_irq();
    rd(LFS_OFF_IRQ_STAT, 32'h1, 32'h3);
    rd(LFS_OFF_STATUS, 32'h11, 32'h93);
    rd(slot(LFS_SEL_PRES, 1), {22'h0, nv[1]}, PM);
    rd(slot(LFS_SEL_NEW, 1), {22'h0, pv[1]}, PM);
    wr(LFS_OFF_IRQ_STAT, 32'h1);
    probe(1'b0);
    // without a reload no further frame event may latch
    repeat (700) @(posedge clk);
    rd(LFS_OFF_IRQ_STAT, 32'h0, 32'h1);
    // masked event latches but keeps the line low
    wr(LFS_OFF_IRQ_MASK, 32'h0);
    prog.reload();
    repeat (700) @(posedge clk);
    rd(LFS_OFF_IRQ_STAT, 32'h1, 32'h1);
    probe(1'b0);
    wr(LFS_OFF_IRQ_MASK, 32'h1);
    probe(1'b1);
    wr(LFS_OFF_CMD, 32'h1 << LFS_CMD_IRQ_OFF);
    probe(1'b0);
    for (int k = 0; k < 4; k++) begin
      acc    = {22'h0, 10'($urandom)};
      acc[0] = k[0];
      wr(LFS_OFF_ACC, acc);
      wr(LFS_OFF_CMD, 32'h1 << LFS_CMD_VOICING);
      rd(LFS_OFF_STATUS, {26'h0, acc[0], 5'h0}, 32'h20);
    end
    // stop sequence: zeros except pitch, ramp down, final frame
    for (int i = 0; i < 12; i++) begin
      wr(slot(LFS_SEL_NEW, i), (i == 0) ? {22'h0, pv[0]} : 32'h0);
    end
    wr(LFS_OFF_IRQ_STAT, 32'h3);
    wr(LFS_OFF_CMD, 32'h1 << LFS_CMD_IRQ_ON);
    prog.reload();
    wr(LFS_OFF_CMD, 32'h1 << LFS_CMD_INTERP);
    repeat (350) @(posedge clk);
    for (int i = 0; i < 12; i++) rd(slot(LFS_SEL_CUR, i), (i == 0) ? {22'h0, pv[0]} : 32'h0, PM);
    wait_irq();
    prog.finish();
    rd(LFS_OFF_STATUS, 32'h0, 32'hD3);
    // a start with an unsafe pitch is flagged, then stopped again
    wr(LFS_OFF_ACC, 32'($urandom_range(11, 0)));
    wr(LFS_OFF_CMD, 32'h1 << LFS_CMD_START);
    rd(LFS_OFF_IRQ_STAT, 32'h2, 32'h2);
    wr(LFS_OFF_CMD, 32'h1 << LFS_CMD_STOP);
    repeat (5) @(posedge clk);
    test_done();
  end
endmodule // test_lfs_frame_seq
